// >>> ucc_cache.sv
// unified level-one cache controller: lookup, fills, write policy, prefetch buffers
//
// Behaviour
// - four ways of 2 Kbytes each, 8 Kbytes total; larger variant doubles.
// - 128 sets per way, 256 in the larger variant, chosen by parameter.
// - 16-byte lines; address bits 3:0 select the byte in a line.
// - one valid flag per line, set only when the whole line is in.
// - code and data reads share the same storage array.
// - non-cacheable read miss: one plain bus read, nothing allocated.
// - cacheable read miss starts a line fill for the whole line.
// - a line fill is four bus transfers of four bytes.
// - fills are bursts, one beat per clock; five clocks at best.
// - write-through: every write makes a bus write cycle.
// - a write hit updates the line's bytes in the array.
// - write-back mode: write hits stay in cache, no bus write.
// - a read hit returns data, one request per clock.
// - two 128-bit prefetch buffers, loaded from a code read hit or a code read fill.
// - the first fill beat carries the requested word, forwarded at once.
`timescale 1ns/1ps
`include "ucc_cfg.svh"

module ucc_cache #(
   parameter int SETS = `UCC_SETS_STD
) (
   input  wire logic                clk_sys_i,
   input  wire logic                arst_n_i,
   input  wire logic                write_back_i,
   input  wire ucc_pkg::ucc_req_type     req_i,
   output logic                     req_ready_o,
   output ucc_pkg::ucc_rsp_type     rsp_o,
   output ucc_pkg::ucc_bus_req_type bus_o,
   input  wire ucc_pkg::ucc_bus_rsp_type bus_i,
   output ucc_pkg::ucc_pfb_type     pfb0_o,
   output ucc_pkg::ucc_pfb_type     pfb1_o
);
   import ucc_pkg::*;

   localparam int IW = $clog2(SETS);
   localparam int TW = 32 - `UCC_OFS_BITS - IW;

   ucc_state_type             state_reg;
   logic [31:0]               addr_reg;
   logic                      code_reg;
   logic [1:0]                victim_reg;
   logic [1:0]                cnt_reg;
   logic [`UCC_LINE_BITS-1:0] line_reg;
   logic                      ready_reg;
   ucc_rsp_type               rsp_reg;
   ucc_bus_req_type           bus_reg;
   ucc_pfb_type               pfb_reg [2];
   logic                      pfb_sel_reg;

   logic [TW-1:0]             tag_mem   [`UCC_WAYS][SETS];
   logic [SETS-1:0]           valid_reg [`UCC_WAYS];
   logic [SETS-1:0]           dirty_reg [`UCC_WAYS];
   logic [2:0]                plru_reg  [SETS];

   logic [IW-1:0]             req_idx;
   logic [TW-1:0]             req_tag;
   logic [IW-1:0]             line_idx;
   logic [IW-1:0]             rd_idx;
   logic [IW-1:0]             wr_idx;
   logic [`UCC_LINE_BITS-1:0] rd_line [`UCC_WAYS];
   logic                      hit;
   logic [1:0]                hit_way;
   logic                      inv_found;
   logic [1:0]                victim;
   logic                      acc;
   logic                      rd_hit;
   logic                      wr_hit;
   logic                      beat;
   logic                      fill_done;
   logic [1:0]                fill_word;
   logic [`UCC_LINE_BITS-1:0] fill_line;

   assign req_idx   = req_i.addr[`UCC_OFS_BITS +: IW];
   assign req_tag   = req_i.addr[31 -: TW];
   assign line_idx  = addr_reg[`UCC_OFS_BITS +: IW];
   assign rd_idx    = (state_reg == ST_IDLE) ? req_idx : line_idx;
   assign wr_idx    = fill_done ? line_idx : req_idx;
   assign acc       = req_i.valid & ready_reg;
   assign rd_hit    = acc & ~req_i.write & hit;
   assign wr_hit    = acc & req_i.write & hit;
   assign beat      = bus_reg.req & bus_i.rdy;
   assign fill_done = (state_reg == ST_FILL) & beat & (cnt_reg == `UCC_LAST_BEAT);
   assign fill_word = addr_reg[3:2] + cnt_reg;

   // code and data lines live in the same ways
   for (genvar g = 0; g < `UCC_WAYS; g++) begin : g_way
      ucc_way #(
         .SETS (SETS),
         .IW   (IW)
      ) u_way (
         .clk_sys_i  (clk_sys_i),
         .rd_idx_i   (rd_idx),
         .wr_idx_i   (wr_idx),
         .line_we_i  (fill_done && (victim_reg == 2'(g))),
         .line_i     (fill_line),
         .word_we_i  (wr_hit && (hit_way == 2'(g))),
         .word_sel_i (req_i.addr[3:2]),
         .be_i       (req_i.be),
         .wdata_i    (req_i.wdata),
         .line_o     (rd_line[g])
      );
   end

   // tag compare and victim choice: invalid way first, else pseudo-LRU
   always_comb begin
      hit       = 1'b0;
      hit_way   = 2'h0;
      inv_found = 1'b0;
      victim    = ucc_plru_victim(plru_reg[req_idx]);
      for (int w = `UCC_WAYS - 1; w >= 0; w--) begin
         if (valid_reg[w][req_idx] && (tag_mem[w][req_idx] == req_tag)) begin
            hit     = 1'b1;
            hit_way = 2'(w);
         end
         if (!valid_reg[w][req_idx]) begin
            inv_found = 1'b1;
            victim    = 2'(w);
         end
      end
   end

   // the last beat is merged here so the whole line is written at once
   always_comb begin
      fill_line                  = line_reg;
      fill_line[32*fill_word +: 32] = bus_i.rdata;
   end

   // sequencing of bus cycles
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg  <= ST_IDLE;
         addr_reg   <= 32'h0000_0000;
         code_reg   <= 1'b0;
         victim_reg <= 2'h0;
         cnt_reg    <= 2'h0;
         ready_reg  <= 1'b1;
         bus_reg    <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (acc) begin
                  addr_reg   <= req_i.addr;
                  code_reg   <= req_i.code;
                  victim_reg <= victim;
                  cnt_reg    <= 2'h0;
                  bus_reg.be <= `UCC_BE_ALL;
                  if (req_i.write) begin
                     if (!(write_back_i && hit)) begin
                        state_reg     <= ST_WRITE;
                        ready_reg     <= 1'b0;
                        bus_reg.req   <= 1'b1;
                        bus_reg.write <= 1'b1;
                        bus_reg.burst <= 1'b0;
                        bus_reg.last  <= 1'b1;
                        bus_reg.addr  <= req_i.addr;
                        bus_reg.wdata <= req_i.wdata;
                        bus_reg.be    <= req_i.be;
                     end
                  end else if (!hit) begin
                     ready_reg     <= 1'b0;
                     bus_reg.req   <= 1'b1;
                     bus_reg.addr  <= {req_i.addr[31:2], 2'h0};
                     if (!req_i.cacheable) begin
                        state_reg     <= ST_SINGLE;
                        bus_reg.write <= 1'b0;
                        bus_reg.burst <= 1'b0;
                        bus_reg.last  <= 1'b1;
                        bus_reg.be    <= req_i.be;
                     end else if (write_back_i && !inv_found && dirty_reg[victim][req_idx]) begin
                        state_reg     <= ST_EVICT;
                        bus_reg.write <= 1'b1;
                        bus_reg.burst <= 1'b1;
                        bus_reg.last  <= 1'b0;
                        bus_reg.addr  <= {tag_mem[victim][req_idx], req_idx, 4'h0};
                        bus_reg.wdata <= ucc_word(rd_line[victim], 2'h0);
                     end else begin
                        state_reg     <= ST_FILL;
                        bus_reg.write <= 1'b0;
                        bus_reg.burst <= 1'b1;
                        bus_reg.last  <= 1'b0;
                     end
                  end
               end
            end
            ST_SINGLE, ST_WRITE: begin
               if (beat) begin
                  state_reg   <= ST_IDLE;
                  ready_reg   <= 1'b1;
                  bus_reg.req <= 1'b0;
               end
            end
            ST_EVICT: begin
               if (beat) begin
                  cnt_reg <= cnt_reg + 2'h1;
                  if (cnt_reg == `UCC_LAST_BEAT) begin
                     state_reg     <= ST_FILL;
                     bus_reg.write <= 1'b0;
                     bus_reg.last  <= 1'b0;
                     bus_reg.addr  <= {addr_reg[31:2], 2'h0};
                  end else begin
                     bus_reg.addr[3:2] <= cnt_reg + 2'h1;
                     bus_reg.wdata     <= ucc_word(rd_line[victim_reg], cnt_reg + 2'h1);
                     bus_reg.last      <= (cnt_reg == 2'h2);
                  end
               end
            end
            ST_FILL: begin
               if (beat) begin
                  cnt_reg <= cnt_reg + 2'h1;
                  if (cnt_reg == `UCC_LAST_BEAT) begin
                     state_reg   <= ST_IDLE;
                     ready_reg   <= 1'b1;
                     bus_reg.req <= 1'b0;
                  end else begin
                     bus_reg.addr[3:2] <= fill_word + 2'h1;
                     bus_reg.last      <= (cnt_reg == 2'h2);
                  end
               end
            end
         endcase
      end
   end

   // incoming fill words collect here until the line is complete
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         line_reg <= '0;
      end else if ((state_reg == ST_FILL) && beat) begin
         line_reg <= fill_line;
      end
   end

   // answers to the requesting unit
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg.valid <= 1'b0;
         if (rd_hit) begin
            rsp_reg.valid <= 1'b1;
            rsp_reg.rdata <= ucc_word(rd_line[hit_way], req_i.addr[3:2]);
         end else if (wr_hit && write_back_i) begin
            rsp_reg.valid <= 1'b1;
            rsp_reg.rdata <= 32'h0000_0000;
         end else if (beat && (state_reg == ST_SINGLE)) begin
            rsp_reg.valid <= 1'b1;
            rsp_reg.rdata <= bus_i.rdata;
         end else if (beat && (state_reg == ST_WRITE)) begin
            rsp_reg.valid <= 1'b1;
            rsp_reg.rdata <= 32'h0000_0000;
         end else if (beat && (state_reg == ST_FILL) && (cnt_reg == 2'h0)) begin
            rsp_reg.valid <= 1'b1;
            rsp_reg.rdata <= bus_i.rdata;
         end
      end
   end

   // tags carry no reset; they are only trusted behind a valid flag
   always_ff @(posedge clk_sys_i) begin
      if (fill_done) begin
         tag_mem[victim_reg][line_idx] <= addr_reg[31 -: TW];
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int w = 0; w < `UCC_WAYS; w++) begin
            valid_reg[w] <= '0;
            dirty_reg[w] <= '0;
         end
      end else if (fill_done) begin
         valid_reg[victim_reg][line_idx] <= 1'b1;
         dirty_reg[victim_reg][line_idx] <= 1'b0;
      end else if (wr_hit && write_back_i) begin
         dirty_reg[hit_way][req_idx] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int s = 0; s < SETS; s++) begin
            plru_reg[s] <= `UCC_PLRU_RST;
         end
      end else if (fill_done) begin
         plru_reg[line_idx] <= ucc_plru_touch(plru_reg[line_idx], victim_reg);
      end else if (rd_hit || wr_hit) begin
         plru_reg[req_idx] <= ucc_plru_touch(plru_reg[req_idx], hit_way);
      end
   end

   // prefetch buffers alternate; a write to a buffered line drops that copy
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pfb_reg[0]  <= '0;
         pfb_reg[1]  <= '0;
         pfb_sel_reg <= 1'b0;
      end else if (rd_hit && req_i.code) begin
         pfb_reg[pfb_sel_reg] <= {1'b1, req_i.addr[31:4], rd_line[hit_way]};
         pfb_sel_reg          <= ~pfb_sel_reg;
      end else if (fill_done && code_reg) begin
         pfb_reg[pfb_sel_reg] <= {1'b1, addr_reg[31:4], fill_line};
         pfb_sel_reg          <= ~pfb_sel_reg;
      end else if (acc && req_i.write) begin
         for (int p = 0; p < 2; p++) begin
            if (pfb_reg[p].line_addr == req_i.addr[31:4]) begin
               pfb_reg[p].valid <= 1'b0;
            end
         end
      end
   end

   assign req_ready_o = ready_reg;
   assign rsp_o       = rsp_reg;
   assign bus_o       = bus_reg;
   assign pfb0_o      = pfb_reg[0];
   assign pfb1_o      = pfb_reg[1];
endmodule

// >>> ucc_cache_monitor.sv
// port-level assertions for the cache controller
`timescale 1ns/1ps
module ucc_cache_monitor #(
   parameter int SETS = 128
) (
   input wire logic                     clk_sys_i,
   input wire logic                     arst_n_i,
   input wire logic                     write_back_i,
   input wire ucc_pkg::ucc_req_type     req_i,
   input wire logic                     req_ready_o,
   input wire ucc_pkg::ucc_rsp_type     rsp_o,
   input wire ucc_pkg::ucc_bus_req_type bus_o,
   input wire ucc_pkg::ucc_bus_rsp_type bus_i,
   input wire ucc_pkg::ucc_pfb_type     pfb0_o,
   input wire ucc_pkg::ucc_pfb_type     pfb1_o
);
   import ucc_pkg::*;
   logic [1:0] beat_reg;
   logic       take;
   logic       beat;
   assign take = req_i.valid && req_ready_o;
   assign beat = bus_o.req && bus_i.rdy;
   // beats already done in the current bus transfer
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         beat_reg <= 2'h0;
      end else if (beat) begin
         beat_reg <= bus_o.last ? 2'h0 : beat_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   a_hit_answer: assert property (take && !req_i.write ##1 req_ready_o
      |-> rsp_o.valid) else $error("read hit not answered next cycle");
   a_last_beat: assert property (bus_o.req && bus_o.burst
      |-> bus_o.last == (beat_reg == 2'h3)) else $error("burst last flag misplaced");
   a_burst_be: assert property (bus_o.req && bus_o.burst
      |-> bus_o.be == 4'hf) else $error("burst byte enables not all set");
   a_burst_wrap: assert property (beat && bus_o.burst && !bus_o.last
      |=> bus_o.req && bus_o.addr[3:2] == $past(bus_o.addr[3:2]) + 2'h1
          && bus_o.addr[31:4] == $past(bus_o.addr[31:4])) else $error("burst address wrong");
   a_first_bypass: assert property (beat && !bus_o.write && beat_reg == 2'h0
      |=> rsp_o.valid && rsp_o.rdata == $past(bus_i.rdata)) else $error("first word not forwarded");
   a_wt_write: assert property (take && req_i.write && !write_back_i
      |=> bus_o.req && bus_o.write && !bus_o.burst && bus_o.wdata == $past(req_i.wdata)
          && bus_o.be == $past(req_i.be)) else $error("write-through cycle missing");
   a_wb_quiet: assert property (take && req_i.write && write_back_i ##1 req_ready_o
      |-> !bus_o.req && rsp_o.valid) else $error("write-back hit reached the bus");
   a_beat_hold: assert property (bus_o.req && !bus_i.rdy
      |=> bus_o.req && $stable(bus_o.addr) && $stable(bus_o.wdata) && $stable(bus_o.write))
      else $error("bus request changed before ready");
   a_evict_fill: assert property (beat && bus_o.burst && bus_o.write && bus_o.last
      |=> bus_o.req && bus_o.burst && !bus_o.write) else $error("fill did not follow eviction");
   a_pfb_drop: assert property (take && req_i.write && pfb0_o.valid
      && pfb0_o.line_addr == req_i.addr[31:4] |=> !pfb0_o.valid) else $error("stale prefetch");
   c_fill: cover property (beat && bus_o.burst && !bus_o.write && bus_o.last);
   c_evict: cover property (beat && bus_o.burst && bus_o.write && bus_o.last);
   c_wb_hit: cover property (take && req_i.write && write_back_i ##1 req_ready_o);
endmodule

bind ucc_cache ucc_cache_monitor #(.SETS(SETS)) u_mon (
   .clk_sys_i    (clk_sys_i),
   .arst_n_i     (arst_n_i),
   .write_back_i (write_back_i),
   .req_i        (req_i),
   .req_ready_o  (req_ready_o),
   .rsp_o        (rsp_o),
   .bus_o        (bus_o),
   .bus_i        (bus_i),
   .pfb0_o       (pfb0_o),
   .pfb1_o       (pfb1_o)
);

// >>> ucc_cache_test.sv
// self-checking bench for the cache controller
`timescale 1ns/1ps
module ucc_cache_test;
   import ucc_pkg::*;
   logic            clk_sys_i;
   logic            arst_n_i;
   logic            write_back;
   logic [1:0]      wait_sel;
   ucc_req_type     req;
   logic            ready;
   ucc_rsp_type     rsp;
   ucc_bus_req_type bus_req;
   ucc_bus_rsp_type bus_rsp;
   ucc_pfb_type     pfb0;
   ucc_pfb_type     pfb1;
   logic [15:0]     rd_beats;
   logic [15:0]     wr_beats;
   logic [31:0]     rdata;
   int              lat;
   int              low;
   int              err_total;
   int              samples_checked;

   ucc_cache #(.SETS(128)) dut (
      .clk_sys_i    (clk_sys_i),
      .arst_n_i     (arst_n_i),
      .write_back_i (write_back),
      .req_i        (req),
      .req_ready_o  (ready),
      .rsp_o        (rsp),
      .bus_o        (bus_req),
      .bus_i        (bus_rsp),
      .pfb0_o       (pfb0),
      .pfb1_o       (pfb1)
   );
   ucc_mem_model mem (
      .clk_sys_i  (clk_sys_i),
      .arst_n_i   (arst_n_i),
      .wait_i     (wait_sel),
      .bus_i      (bus_req),
      .bus_o      (bus_rsp),
      .rd_beats_o (rd_beats),
      .wr_beats_o (wr_beats)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [31:0] exp_word(input logic [31:0] a);
      return {a[31:2], 2'h0} ^ 32'h5a5a_0000;
   endfunction

   task automatic final_report();
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [127:0] exp, input logic [127:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_beats(input logic [15:0] r0, input logic [15:0] w0, input int dr,
                            input int dw);
      cmp("read beats", r0 + 16'(dr), rd_beats);
      cmp("write beats", w0 + 16'(dw), wr_beats);
   endtask

   // one core request; lat counts cycles to the answer, low the cycles with ready low
   task automatic send(input logic wr, input logic code, input logic cach, input logic [31:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
      int n;
      @(posedge clk_sys_i);
      #1;
      req = '{1'b1, wr, code, cach, a, wd, be};
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      @(posedge clk_sys_i);
      #1;
      req.valid = 1'b0;
      lat = 0;
      low = 0;
      for (n = (n < 100) ? 1 : 100; n < 100; n++) begin
         if (ready !== 1'b1) low++;
         if (rsp.valid === 1'b1 && lat == 0) begin
            lat = n;
            rdata = rsp.rdata;
         end
         if (lat != 0 && ready === 1'b1) break;
         @(posedge clk_sys_i);
         #1;
      end
      if (n >= 100) begin
         err_total++;
         final_report();
      end
   endtask

   task automatic t_hits(input logic [31:0] a);
      for (int k = 0; k < 5; k++) begin
         if (k > 0) begin
            cmp("hit valid", 1, rsp.valid);
            cmp("hit data", exp_word({a[31:4], 2'(k - 1), 2'h0}), rsp.rdata);
         end
         req = '{k < 4, 1'b0, 1'b0, 1'b1, {a[31:4], 2'(k), 2'h0}, 32'h0, 4'hf};
         @(posedge clk_sys_i);
         #1;
      end
   endtask

   task automatic t_fill_hits();
      logic [15:0]  r0;
      logic [15:0]  w0;
      logic [127:0] ln;
      logic [31:0]  a;
      a = 32'h0000_1028;
      r0 = rd_beats;
      w0 = wr_beats;
      for (int k = 0; k < 4; k++) ln[32*k +: 32] = exp_word({a[31:4], 2'(k), 2'h0});
      send(1'b0, 1'b1, 1'b1, a, 32'h0, 4'hf);
      cmp("fill first word", exp_word(a), rdata);
      cmp("fill first latency", 2, lat);
      cmp("fill busy cycles", 4, low);
      chk_beats(r0, w0, 4, 0);
      @(posedge clk_sys_i);
      #1;
      cmp("prefetch valid", 1, pfb0.valid);
      cmp("prefetch address", a[31:4], pfb0.line_addr);
      cmp("prefetch line", ln, pfb0.line);
      t_hits(a);
      send(1'b0, 1'b1, 1'b1, a, 32'h0, 4'hf);
      cmp("hit latency", 1, lat);
      @(posedge clk_sys_i);
      #1;
      cmp("second prefetch line", ln, pfb1.line);
      chk_beats(r0, w0, 4, 0);
   endtask

   task automatic t_slow();
      logic [15:0] r0;
      logic [15:0] w0;
      r0 = rd_beats;
      w0 = wr_beats;
      wait_sel = 2'h2;
      send(1'b0, 1'b0, 1'b1, 32'h0000_1824, 32'h0, 4'hf);
      wait_sel = 2'h0;
      cmp("slow first word", exp_word(32'h0000_1824), rdata);
      cmp("slow first latency", 4, lat);
      cmp("slow busy cycles", 12, low);
      chk_beats(r0, w0, 4, 0);
   endtask

   task automatic t_nocache();
      logic [15:0] r0;
      logic [15:0] w0;
      r0 = rd_beats;
      w0 = wr_beats;
      for (int n = 0; n < 2; n++) begin
         send(1'b0, 1'b0, 1'b0, 32'h0000_3f04, 32'h0, 4'hf);
         cmp("uncached word", exp_word(32'h0000_3f04), rdata);
         chk_beats(r0, w0, n + 1, 0);
      end
   endtask

   task automatic t_wt();
      logic [15:0] r0;
      logic [15:0] w0;
      logic [31:0] e;
      r0 = rd_beats;
      w0 = wr_beats;
      e = exp_word(32'h0000_1024);
      send(1'b1, 1'b0, 1'b1, 32'h0000_1024, 32'hdead_beef, 4'h3);
      chk_beats(r0, w0, 0, 1);
      cmp("prefetch 0 dropped", 0, pfb0.valid);
      cmp("prefetch 1 dropped", 0, pfb1.valid);
      send(1'b0, 1'b0, 1'b1, 32'h0000_1024, 32'h0, 4'hf);
      cmp("merged word", {e[31:16], 16'hbeef}, rdata);
      send(1'b1, 1'b0, 1'b1, 32'h0000_2f40, 32'h1234_5678, 4'hf);
      send(1'b0, 1'b0, 1'b1, 32'h0000_2f40, 32'h0, 4'hf);
      cmp("written miss word", 32'h1234_5678, rdata);
      chk_beats(r0, w0, 4, 2);
   endtask

   task automatic t_wb();
      logic [15:0] r0;
      logic [15:0] w0;
      write_back = 1'b1;
      send(1'b0, 1'b0, 1'b1, 32'h0000_2028, 32'h0, 4'hf);
      send(1'b0, 1'b0, 1'b1, 32'h0000_2828, 32'h0, 4'hf);
      r0 = rd_beats;
      w0 = wr_beats;
      for (int k = 0; k < 4; k++) begin
         send(1'b1, 1'b0, 1'b1, 32'h0000_1028 + 32'(k) * 32'h0000_0800, 32'(k), 4'hf);
         cmp("write-back hit latency", 1, lat);
      end
      chk_beats(r0, w0, 0, 0);
      send(1'b1, 1'b0, 1'b1, 32'h0000_3f04, 32'h9, 4'hf);
      cmp("wb miss latency", 2, lat);
      send(1'b0, 1'b0, 1'b1, 32'h0000_3028, 32'h0, 4'hf);
      cmp("replacing fill word", exp_word(32'h0000_3028), rdata);
      cmp("eviction latency", 6, lat);
      cmp("eviction busy cycles", 8, low);
      chk_beats(r0, w0, 4, 5);
      send(1'b0, 1'b0, 1'b1, 32'h0000_1028, 32'h0, 4'hf);
      cmp("evicted word", 0, rdata);
      chk_beats(r0, w0, 8, 9);
      write_back = 1'b0;
   endtask

   initial begin
      err_total = 0;
      samples_checked = 0;
      arst_n_i = 1'b0;
      write_back = 1'b0;
      wait_sel = 2'h0;
      req = '0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      arst_n_i = 1'b1;
      t_fill_hits();
      t_slow();
      t_nocache();
      t_wt();
      t_wb();
      final_report();
   end
endmodule

// >>> ucc_cfg.svh
// constants for the unified level-one cache controller
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH

`define UCC_WAYS       4
`define UCC_SETS_STD   128
`define UCC_SETS_BIG   256
`define UCC_LINE_BYTES 16
`define UCC_LINE_BITS  128
`define UCC_WORD_BITS  32
`define UCC_OFS_BITS   4
`define UCC_BEATS      4
`define UCC_LAST_BEAT  2'h3
`define UCC_PLRU_RST   3'h0
`define UCC_BE_ALL     4'hf
`define UCC_FILL_CLKS  5

`endif

// >>> ucc_mem_model.sv
// external memory model on the far side of the cache bus port
`timescale 1ns/1ps
module ucc_mem_model (
   input  wire logic                     clk_sys_i,
   input  wire logic                     arst_n_i,
   input  wire logic [1:0]               wait_i,
   input  wire ucc_pkg::ucc_bus_req_type bus_i,
   output ucc_pkg::ucc_bus_rsp_type      bus_o,
   output logic      [15:0]              rd_beats_o,
   output logic      [15:0]              wr_beats_o
);
   import ucc_pkg::*;
   logic [31:0] mem [0:4095];
   logic [1:0]  wait_reg;
   logic [31:0] last_reg;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = {18'h0, 12'(i), 2'h0} ^ 32'h5a5a_0000;
      end
   end
   // every beat may take wait_i extra cycles; zero keeps pace with bursts
   always_comb begin
      bus_o.rdy   = bus_i.req && (wait_reg == wait_i);
      bus_o.rdata = (bus_o.rdy && !bus_i.write) ? mem[bus_i.addr[13:2]] : ~last_reg;
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_reg   <= 2'h0;
         last_reg   <= 32'h0;
         rd_beats_o <= 16'h0;
         wr_beats_o <= 16'h0;
      end else begin
         wait_reg <= (bus_i.req && !bus_o.rdy) ? wait_reg + 2'h1 : 2'h0;
         if (bus_o.rdy) begin
            last_reg <= bus_o.rdata;
            if (bus_i.write) begin
               wr_beats_o <= wr_beats_o + 16'h1;
            end else begin
               rd_beats_o <= rd_beats_o + 16'h1;
            end
         end
      end
   end
   always @(posedge clk_sys_i) begin
      if (bus_o.rdy && bus_i.write) begin
         for (int b = 0; b < 4; b++) begin
            if (bus_i.be[b]) begin
               mem[bus_i.addr[13:2]][8*b +: 8] <= bus_i.wdata[8*b +: 8];
            end
         end
      end
   end
endmodule

// >>> ucc_pkg.sv
// types and helper functions of the unified level-one cache controller
`include "ucc_cfg.svh"

package ucc_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_SINGLE, ST_WRITE, ST_EVICT, ST_FILL} ucc_state_type;

   typedef struct packed {
      logic                      valid;
      logic                      write;
      logic                      code;
      logic                      cacheable;
      logic [31:0]               addr;
      logic [`UCC_WORD_BITS-1:0] wdata;
      logic [3:0]                be;
   } ucc_req_type;

   typedef struct packed {
      logic                      valid;
      logic [`UCC_WORD_BITS-1:0] rdata;
   } ucc_rsp_type;

   typedef struct packed {
      logic                      req;
      logic                      write;
      logic                      burst;
      logic                      last;
      logic [31:0]               addr;
      logic [`UCC_WORD_BITS-1:0] wdata;
      logic [3:0]                be;
   } ucc_bus_req_type;

   typedef struct packed {
      logic                      rdy;
      logic [`UCC_WORD_BITS-1:0] rdata;
   } ucc_bus_rsp_type;

   typedef struct packed {
      logic                      valid;
      logic [27:0]               line_addr;
      logic [`UCC_LINE_BITS-1:0] line;
   } ucc_pfb_type;

   function automatic logic [`UCC_WORD_BITS-1:0] ucc_word(
      input logic [`UCC_LINE_BITS-1:0] line,
      input logic [1:0]                sel);
      ucc_word = line[32*sel +: 32];
   endfunction

   // tree bits point at the victim: bit0 picks the half, bit1/bit2 the way
   function automatic logic [1:0] ucc_plru_victim(input logic [2:0] bits);
      ucc_plru_victim = bits[0] ? {1'b1, bits[2]} : {1'b0, bits[1]};
   endfunction

   function automatic logic [2:0] ucc_plru_touch(input logic [2:0] bits, input logic [1:0] way);
      logic [2:0] res;
      res    = bits;
      res[0] = ~way[1];
      if (way[1]) begin
         res[2] = ~way[0];
      end else begin
         res[1] = ~way[0];
      end
      ucc_plru_touch = res;
   endfunction

endpackage

// >>> ucc_way.sv
// one way of line storage with whole-line and byte-lane write ports
`timescale 1ns/1ps
`include "ucc_cfg.svh"

module ucc_way #(
   parameter int SETS = `UCC_SETS_STD,
   parameter int IW   = $clog2(SETS)
) (
   input  wire logic                      clk_sys_i,
   input  wire logic [IW-1:0]             rd_idx_i,
   input  wire logic [IW-1:0]             wr_idx_i,
   input  wire logic                      line_we_i,
   input  wire logic [`UCC_LINE_BITS-1:0] line_i,
   input  wire logic                      word_we_i,
   input  wire logic [1:0]                word_sel_i,
   input  wire logic [3:0]                be_i,
   input  wire logic [`UCC_WORD_BITS-1:0] wdata_i,
   output logic      [`UCC_LINE_BITS-1:0] line_o
);
   logic [`UCC_LINE_BITS-1:0] mem [SETS];

   always_ff @(posedge clk_sys_i) begin
      if (line_we_i) begin
         mem[wr_idx_i] <= line_i;
      end else if (word_we_i) begin
         for (int b = 0; b < 4; b++) begin
            if (be_i[b]) begin
               mem[wr_idx_i][32*word_sel_i + 8*b +: 8] <= wdata_i[8*b +: 8];
            end
         end
      end
   end

   assign line_o = mem[rd_idx_i];
endmodule
